// File: rtl/pei_pkg.sv
// Shared constants and frame helpers for the print engine link
package pei_pkg;
	// ************************************************************
	// Timing
	// ************************************************************
	localparam int CLK_HZ = 250_000_000;
	localparam int BAUD_BPS = 9600;
	localparam int CNT_W = 16;
	// Nearest-below bit period; the 0.0026% error is far inside UART slack
	localparam logic [CNT_W-1:0] BIT_CYC = CNT_W'(CLK_HZ / BAUD_BPS);

	// ************************************************************
	// Frame layout
	// ************************************************************
	localparam int DATA_BITS = 8;
	localparam int FRAME_BITS = 11;
	localparam int IDX_W = 4;
	localparam logic [IDX_W-1:0] FRAME_LAST = IDX_W'(FRAME_BITS - 1);
	localparam logic LINE_IDLE = 1'b1;
	localparam logic [DATA_BITS-1:0] INIT_CMD = 8'h01;

	// ************************************************************
	// Sizes and reset values
	// ************************************************************
	localparam int FIFO_DEPTH = 16;
	localparam int KEY_W = 8;
	localparam int PIX_W = 16;
	localparam logic [PIX_W-1:0] LINE_PIXELS = 16'h1000;
	// {command, request_n, video_p, video_n}
	localparam logic [3:0] ENG_SYNC_RST = 4'hD;
	// {status, ready_n, key_n, hsync_n, vsync_n}
	localparam logic [4:0] CTL_SYNC_RST = 5'h1F;

	// Start bit, data LSB first, odd parity, stop bit
	function automatic logic [FRAME_BITS-1:0] frame_build(input logic [DATA_BITS-1:0] d);
		return {LINE_IDLE, ~(^d), d, ~LINE_IDLE};
	endfunction

	// Start low, stop high, odd ones over data and parity
	function automatic logic frame_good(input logic [FRAME_BITS-1:0] f);
		return (f[0] == ~LINE_IDLE) && (f[FRAME_BITS-1] == LINE_IDLE) && (^f[FRAME_BITS-2:1]);
	endfunction
endpackage

// File: rtl/pei_if.sv
// Wires between the print engine and the video controller
interface pei_if;
	logic command;
	logic status;
	logic engine_ready_n;
	logic print_request_n;
	logic key_change_n;
	logic vsync_n;
	logic hsync_n;
	logic video_p;
	logic video_n;

	modport engine (
		input command, print_request_n, video_p, video_n,
		output status, engine_ready_n, key_change_n, vsync_n, hsync_n
	);
	modport controller (
		output command, print_request_n, video_p, video_n,
		input status, engine_ready_n, key_change_n, vsync_n, hsync_n
	);
endinterface

// File: rtl/pei_fifo.sv
// Flip-flop FIFO with valid/ready on both sides
module pei_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 16
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic arst_n_i,
	// Fill side
	input wire logic in_valid_i,
	input wire logic [WIDTH-1:0] in_data_i,
	output logic in_ready_o,
	// Drain side
	output logic out_valid_o,
	output logic [WIDTH-1:0] out_data_o,
	input wire logic out_ready_i
);
	localparam int PW = $clog2(DEPTH);
	localparam logic [PW:0] FULL = (PW + 1)'(DEPTH);
	localparam logic [PW-1:0] LAST = PW'(DEPTH - 1);

	logic [WIDTH-1:0] mem_reg [DEPTH];
	logic [PW-1:0] wr_reg, wr_next, rd_reg, rd_next;
	logic [PW:0] cnt_reg, cnt_next;
	logic push, pop;

	assign in_ready_o = (cnt_reg != FULL);
	assign out_valid_o = (cnt_reg != '0);
	assign out_data_o = mem_reg[rd_reg];
	assign push = in_valid_i && in_ready_o;
	assign pop = out_valid_o && out_ready_i;

	always_comb begin
		wr_next = wr_reg;
		rd_next = rd_reg;
		if (push) begin
			wr_next = (wr_reg == LAST) ? '0 : wr_reg + 1'b1;
		end
		if (pop) begin
			rd_next = (rd_reg == LAST) ? '0 : rd_reg + 1'b1;
		end
		cnt_next = cnt_reg + (PW + 1)'(push) - (PW + 1)'(pop);
	end

	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			wr_reg <= '0;
			rd_reg <= '0;
			cnt_reg <= '0;
		end else begin
			wr_reg <= wr_next;
			rd_reg <= rd_next;
			cnt_reg <= cnt_next;
		end
	end

	// Storage has no reset; only written slots are ever read
	always_ff @(posedge clk_i) begin
		if (push) begin
			mem_reg[wr_reg] <= in_data_i;
		end
	end
endmodule

// File: rtl/pei_controller.sv
// Video controller end: command sender, status receiver, video shifter
module pei_controller #(
	parameter logic [pei_pkg::CNT_W-1:0] BIT_CYCLES = pei_pkg::BIT_CYC,
	parameter logic [pei_pkg::PIX_W-1:0] LINE_PIXELS = pei_pkg::LINE_PIXELS,
	parameter int FIFO_DEPTH = pei_pkg::FIFO_DEPTH
) (
	// Clock and reset
	input wire logic CLK_I,
	input wire logic ARST_N_I,
	// Link
	pei_if.controller LINK,
	// Commands in
	input wire logic CMD_VALID_I,
	input wire logic [pei_pkg::DATA_BITS-1:0] CMD_DATA_I,
	output logic CMD_READY_O,
	// Status out
	output logic STAT_VALID_O,
	output logic [pei_pkg::DATA_BITS-1:0] STAT_DATA_O,
	output logic STAT_ERR_O,
	// Engine state and print control
	input wire logic PRINT_REQ_I,
	output logic ENG_READY_O,
	output logic KEY_CHANGED_O,
	output logic PAGE_ACTIVE_O,
	// Video pixels
	input wire logic VID_VALID_I,
	input wire logic VID_DATA_I,
	output logic VID_READY_O
);
	typedef enum logic [2:0] {C_BOOT, C_IDLE, C_TX, C_WAIT, C_RX} pei_ctl_state_e;

	pei_ctl_state_e state_reg, state_next;
	logic [pei_pkg::CNT_W-1:0] cnt_reg, cnt_next;
	logic [pei_pkg::IDX_W-1:0] idx_reg, idx_next;
	logic [pei_pkg::FRAME_BITS-1:0] sh_reg, sh_next;
	logic tx_reg, tx_next, sprev_reg, sprev_next, hprev_reg, hprev_next;
	logic [4:0] s1_reg, s2_reg, s3_reg, flt_reg, flt_next;
	logic sv_reg, sv_next, se_reg, se_next, preq_reg, preq_next;
	logic [pei_pkg::DATA_BITS-1:0] sd_reg, sd_next;
	logic [pei_pkg::PIX_W-1:0] pix_reg, pix_next;
	logic vp_reg, vp_next, vn_reg, vn_next;
	logic q_valid, q_ready;
	logic [pei_pkg::DATA_BITS-1:0] q_data;

	// ************************************************************
	// Command queue
	// ************************************************************
	pei_fifo #(.WIDTH(pei_pkg::DATA_BITS), .DEPTH(FIFO_DEPTH)) u_cmd_fifo (
		.clk_i(CLK_I),
		.arst_n_i(ARST_N_I),
		.in_valid_i(CMD_VALID_I),
		.in_data_i(CMD_DATA_I),
		.in_ready_o(CMD_READY_O),
		.out_valid_o(q_valid),
		.out_data_o(q_data),
		.out_ready_i(q_ready)
	);
	// Next command only leaves once the previous reply is
	assign q_ready = (state_reg == C_IDLE);

	assign LINK.command = tx_reg;
	assign LINK.print_request_n = preq_reg;
	assign LINK.video_p = vp_reg;
	assign LINK.video_n = vn_reg;
	assign STAT_VALID_O = sv_reg;
	assign STAT_DATA_O = sd_reg;
	assign STAT_ERR_O = se_reg;
	assign ENG_READY_O = ~flt_reg[3];
	assign KEY_CHANGED_O = ~flt_reg[2];
	assign PAGE_ACTIVE_O = ~flt_reg[0];
	assign VID_READY_O = (pix_reg != '0);

	// ************************************************************
	// Next state
	// ************************************************************
	always_comb begin
		state_next = state_reg;
		cnt_next = cnt_reg;
		idx_next = idx_reg;
		sh_next = sh_reg;
		tx_next = tx_reg;
		sv_next = 1'b0;
		se_next = 1'b0;
		sd_next = sd_reg;
		flt_next = (s2_reg & s3_reg) | (flt_reg & (s2_reg ^ s3_reg));
		sprev_next = flt_reg[4];
		hprev_next = flt_reg[1];
		preq_next = ~PRINT_REQ_I;
		pix_next = pix_reg;
		vp_next = 1'b0;
		case (state_reg)
			C_BOOT, C_IDLE: begin
				// Init goes out before anything from the queue
				if (state_reg == C_BOOT || q_valid) begin
					sh_next = pei_pkg::frame_build((state_reg == C_BOOT) ? pei_pkg::INIT_CMD : q_data);
					tx_next = sh_next[0];
					sh_next = {pei_pkg::LINE_IDLE, sh_next[pei_pkg::FRAME_BITS-1:1]};
					cnt_next = BIT_CYCLES - 1'b1;
					idx_next = '0;
					state_next = C_TX;
				end
			end
			C_TX: begin
				if (cnt_reg != '0) begin
					cnt_next = cnt_reg - 1'b1;
				end else if (idx_reg == pei_pkg::FRAME_LAST) begin
					state_next = C_WAIT;
				end else begin
					tx_next = sh_reg[0];
					sh_next = {pei_pkg::LINE_IDLE, sh_reg[pei_pkg::FRAME_BITS-1:1]};
					idx_next = idx_reg + 1'b1;
					cnt_next = BIT_CYCLES - 1'b1;
				end
			end
			C_WAIT: begin
				if (sprev_reg && !flt_reg[4]) begin
					cnt_next = BIT_CYCLES >> 1;
					idx_next = '0;
					state_next = C_RX;
				end
			end
			C_RX: begin
				if (cnt_reg != '0) begin
					cnt_next = cnt_reg - 1'b1;
				end else if (idx_reg == pei_pkg::FRAME_LAST + 1'b1) begin
					// Engine still sends its stop bit after our mid-bit sample
					state_next = C_IDLE;
				end else begin
					sh_next = {flt_reg[4], sh_reg[pei_pkg::FRAME_BITS-1:1]};
					cnt_next = BIT_CYCLES - 1'b1;
					idx_next = idx_reg + 1'b1;
					if (idx_reg == pei_pkg::FRAME_LAST) begin
						// Bad frames are flagged, never delivered
						if (pei_pkg::frame_good(sh_next)) begin
							sv_next = 1'b1;
							sd_next = sh_next[pei_pkg::DATA_BITS:1];
						end else begin
							se_next = 1'b1;
						end
					end
				end
			end
			default: state_next = C_BOOT;
		endcase
		// Line starts on the falling hsync edge within a page
		if (pix_reg != '0) begin
			pix_next = pix_reg - 1'b1;
			vp_next = VID_VALID_I && VID_DATA_I;
		end else if (hprev_reg && !flt_reg[1] && !flt_reg[0]) begin
			pix_next = LINE_PIXELS;
		end
		vn_next = ~vp_next;
	end

	// ************************************************************
	// Registers
	// ************************************************************
	always_ff @(posedge CLK_I or negedge ARST_N_I) begin
		if (!ARST_N_I) begin
			state_reg <= C_BOOT;
			cnt_reg <= '0;
			idx_reg <= '0;
			sh_reg <= '0;
			tx_reg <= pei_pkg::LINE_IDLE;
			s1_reg <= pei_pkg::CTL_SYNC_RST;
			s2_reg <= pei_pkg::CTL_SYNC_RST;
			s3_reg <= pei_pkg::CTL_SYNC_RST;
			flt_reg <= pei_pkg::CTL_SYNC_RST;
			sprev_reg <= pei_pkg::LINE_IDLE;
			hprev_reg <= 1'b1;
			sv_reg <= 1'b0;
			se_reg <= 1'b0;
			sd_reg <= '0;
			preq_reg <= 1'b1;
			pix_reg <= '0;
			vp_reg <= 1'b0;
			vn_reg <= 1'b1;
		end else begin
			state_reg <= state_next;
			cnt_reg <= cnt_next;
			idx_reg <= idx_next;
			sh_reg <= sh_next;
			tx_reg <= tx_next;
			s1_reg <= {LINK.status, LINK.engine_ready_n, LINK.key_change_n,
				LINK.hsync_n, LINK.vsync_n};
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
			flt_reg <= flt_next;
			sprev_reg <= sprev_next;
			hprev_reg <= hprev_next;
			sv_reg <= sv_next;
			se_reg <= se_next;
			sd_reg <= sd_next;
			preq_reg <= preq_next;
			pix_reg <= pix_next;
			vp_reg <= vp_next;
			vn_reg <= vn_next;
		end
	end
endmodule

// File: rtl/pei_engine.sv
// Print engine end: command receiver, status sender, sync and state lines
module pei_engine #(
	parameter logic [pei_pkg::CNT_W-1:0] BIT_CYCLES = pei_pkg::BIT_CYC,
	parameter int KEY_W = pei_pkg::KEY_W
) (
	// Clock and reset
	input wire logic CLK_I,
	input wire logic ARST_N_I,
	// Link
	pei_if.engine LINK,
	// Commands out
	output logic CMD_VALID_O,
	output logic [pei_pkg::DATA_BITS-1:0] CMD_DATA_O,
	output logic CMD_ERR_O,
	output logic LINK_UP_O,
	// Status in
	input wire logic STAT_VALID_I,
	input wire logic [pei_pkg::DATA_BITS-1:0] STAT_DATA_I,
	output logic STAT_READY_O,
	// Engine state
	input wire logic READY_I,
	input wire logic [KEY_W-1:0] KEY_I,
	// Page timing
	input wire logic VSYNC_I,
	input wire logic HSYNC_I,
	// Print request and video
	output logic PRINT_REQ_O,
	output logic VIDEO_BIT_O
);
	typedef enum logic [1:0] {E_IDLE, E_RX, E_WAIT, E_TX} pei_eng_state_e;

	// ************************************************************
	// State
	// ************************************************************
	pei_eng_state_e state_reg, state_next;
	logic [pei_pkg::CNT_W-1:0] cnt_reg, cnt_next;
	logic [pei_pkg::IDX_W-1:0] idx_reg, idx_next;
	logic [pei_pkg::FRAME_BITS-1:0] sh_reg, sh_next;
	logic tx_reg, tx_next;
	logic cprev_reg, cprev_next;
	logic [3:0] s1_reg, s2_reg, s3_reg, flt_reg, flt_next;
	logic cv_reg, cv_next, ce_reg, ce_next;
	logic [pei_pkg::DATA_BITS-1:0] cd_reg, cd_next;
	logic up_reg, up_next;
	logic [KEY_W-1:0] kprev_reg, kprev_next;
	logic kchg_reg, kchg_next, key_clear;
	logic rdy_reg, rdy_next;
	logic vs_reg, vs_next, hs_reg, hs_next;
	logic preq_reg, preq_next, vid_reg, vid_next;
	logic cmd_line;

	// Filtered copies: command, request_n, video_p, video_n
	assign cmd_line = flt_reg[3];

	// ************************************************************
	// Outputs
	// ************************************************************
	assign LINK.status = tx_reg;
	assign LINK.engine_ready_n = ~rdy_reg;
	assign LINK.key_change_n = ~kchg_reg;
	assign LINK.vsync_n = ~vs_reg;
	assign LINK.hsync_n = ~hs_reg;
	assign CMD_VALID_O = cv_reg;
	assign CMD_DATA_O = cd_reg;
	assign CMD_ERR_O = ce_reg;
	assign LINK_UP_O = up_reg;
	// Reply is only taken after a good command
	assign STAT_READY_O = (state_reg == E_WAIT);
	assign PRINT_REQ_O = preq_reg;
	assign VIDEO_BIT_O = vid_reg;

	// ************************************************************
	// Next state
	// ************************************************************
	always_comb begin
		state_next = state_reg;
		cnt_next = cnt_reg;
		idx_next = idx_reg;
		sh_next = sh_reg;
		tx_next = tx_reg;
		cv_next = 1'b0;
		ce_next = 1'b0;
		cd_next = cd_reg;
		up_next = up_reg;
		key_clear = 1'b0;
		// Only take a level once the last two stages agree
		flt_next = (s2_reg & s3_reg) | (flt_reg & (s2_reg ^ s3_reg));
		cprev_next = cmd_line;
		case (state_reg)
			E_IDLE: begin
				// Start bit is a falling edge on an idle-high line
				if (cprev_reg && !cmd_line) begin
					cnt_next = BIT_CYCLES >> 1;
					idx_next = '0;
					state_next = E_RX;
				end
			end
			E_RX: begin
				if (cnt_reg != '0) begin
					cnt_next = cnt_reg - 1'b1;
				end else if (idx_reg == pei_pkg::FRAME_LAST + 1'b1) begin
					// Reply only once the command stop bit is over
					state_next = E_WAIT;
				end else begin
					// Mid-bit sample, LSB first
					sh_next = {cmd_line, sh_reg[pei_pkg::FRAME_BITS-1:1]};
					cnt_next = BIT_CYCLES - 1'b1;
					idx_next = idx_reg + 1'b1;
					if (idx_reg == pei_pkg::FRAME_LAST) begin
						state_next = E_IDLE;
						if (!pei_pkg::frame_good(sh_next)) begin
							ce_next = 1'b1;
						end else if (up_reg || sh_next[pei_pkg::DATA_BITS:1] == pei_pkg::INIT_CMD) begin
							// Nothing passes until the link is opened
							up_next = 1'b1;
							cv_next = 1'b1;
							cd_next = sh_next[pei_pkg::DATA_BITS:1];
							key_clear = 1'b1;
							// One more bit time in receive before the reply
							state_next = E_RX;
						end
					end
				end
			end
			E_WAIT: begin
				// Own line, but only ever as a reply, so link stays half duplex
				if (STAT_VALID_I) begin
					sh_next = pei_pkg::frame_build(STAT_DATA_I);
					tx_next = sh_next[0];
					sh_next = {pei_pkg::LINE_IDLE, sh_next[pei_pkg::FRAME_BITS-1:1]};
					cnt_next = BIT_CYCLES - 1'b1;
					idx_next = '0;
					state_next = E_TX;
				end
			end
			E_TX: begin
				if (cnt_reg != '0) begin
					cnt_next = cnt_reg - 1'b1;
				end else if (idx_reg == pei_pkg::FRAME_LAST) begin
					state_next = E_IDLE;
				end else begin
					tx_next = sh_reg[0];
					sh_next = {pei_pkg::LINE_IDLE, sh_reg[pei_pkg::FRAME_BITS-1:1]};
					idx_next = idx_reg + 1'b1;
					cnt_next = BIT_CYCLES - 1'b1;
				end
			end
			default: state_next = E_IDLE;
		endcase
		// A key edge in the clearing cycle still sets the flag
		kprev_next = KEY_I;
		kchg_next = kchg_reg;
		if (KEY_I != kprev_reg) begin
			kchg_next = 1'b1;
		end else if (key_clear) begin
			kchg_next = 1'b0;
		end
		rdy_next = READY_I;
		vs_next = VSYNC_I;
		hs_next = HSYNC_I;
		preq_next = ~flt_reg[2];
		// Differential pair must disagree to carry a dot
		vid_next = flt_reg[1] && !flt_reg[0];
	end

	// ************************************************************
	// Registers
	// ************************************************************
	always_ff @(posedge CLK_I or negedge ARST_N_I) begin
		if (!ARST_N_I) begin
			state_reg <= E_IDLE;
			cnt_reg <= '0;
			idx_reg <= '0;
			sh_reg <= '0;
			tx_reg <= pei_pkg::LINE_IDLE;
			cprev_reg <= pei_pkg::LINE_IDLE;
			s1_reg <= pei_pkg::ENG_SYNC_RST;
			s2_reg <= pei_pkg::ENG_SYNC_RST;
			s3_reg <= pei_pkg::ENG_SYNC_RST;
			flt_reg <= pei_pkg::ENG_SYNC_RST;
			cv_reg <= 1'b0;
			ce_reg <= 1'b0;
			cd_reg <= '0;
			up_reg <= 1'b0;
			kprev_reg <= '0;
			kchg_reg <= 1'b0;
			rdy_reg <= 1'b0;
			vs_reg <= 1'b0;
			hs_reg <= 1'b0;
			preq_reg <= 1'b0;
			vid_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			cnt_reg <= cnt_next;
			idx_reg <= idx_next;
			sh_reg <= sh_next;
			tx_reg <= tx_next;
			cprev_reg <= cprev_next;
			s1_reg <= {LINK.command, LINK.print_request_n, LINK.video_p, LINK.video_n};
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
			flt_reg <= flt_next;
			cv_reg <= cv_next;
			ce_reg <= ce_next;
			cd_reg <= cd_next;
			up_reg <= up_next;
			kprev_reg <= kprev_next;
			kchg_reg <= kchg_next;
			rdy_reg <= rdy_next;
			vs_reg <= vs_next;
			hs_reg <= hs_next;
			preq_reg <= preq_next;
			vid_reg <= vid_next;
		end
	end
endmodule

// File: verif/pei_link_props.sv
// Concurrent checks on the wires between print engine and video controller
module pei_link_props #(
	parameter logic [pei_pkg::CNT_W-1:0] BIT_CYCLES = pei_pkg::BIT_CYC
) (
	// Clock and reset
	input wire logic CLK_I,
	input wire logic ARST_N_I,
	// Byte link
	input wire logic command,
	input wire logic status,
	// State and sync lines
	input wire logic engine_ready_n,
	input wire logic print_request_n,
	input wire logic key_change_n,
	input wire logic vsync_n,
	input wire logic hsync_n,
	// Video pair
	input wire logic video_p,
	input wire logic video_n
);
	timeunit 1ns;
	timeprecision 1ps;
	localparam int BIT_I = int'(BIT_CYCLES);
	// ************************************************************
	// Low-run counters
	// ************************************************************
	// Low runs must be whole bit times, at most start plus eight zeros
	logic [19:0] cmd_low_reg;
	logic [19:0] cmd_low_next;
	logic [19:0] stat_low_reg;
	logic [19:0] stat_low_next;
	always_comb begin
		cmd_low_next = command ? 20'h00000 : cmd_low_reg + 20'h00001;
		stat_low_next = status ? 20'h00000 : stat_low_reg + 20'h00001;
	end
	always_ff @(posedge CLK_I or negedge ARST_N_I) begin
		if (!ARST_N_I) begin
			cmd_low_reg <= 20'h00000;
			stat_low_reg <= 20'h00000;
		end else begin
			cmd_low_reg <= cmd_low_next;
			stat_low_reg <= stat_low_next;
		end
	end
	// ************************************************************
	// Properties
	// ************************************************************
	default clocking cb @(posedge CLK_I);
	endclocking
	default disable iff (!ARST_N_I);
	property p_video_pair;
		video_p != video_n;
	endproperty
	a_video_pair: assert property (p_video_pair)
		else $error("video pair lines not complementary");
	property p_half_duplex;
		command || status;
	endproperty
	a_half_duplex: assert property (p_half_duplex)
		else $error("both byte lines active at once");
	property p_cmd_bits;
		$rose(command) |-> (cmd_low_reg % BIT_I == 0) && (cmd_low_reg <= 9 * BIT_I);
	endproperty
	a_cmd_bits: assert property (p_cmd_bits)
		else $error("command low run not whole bit times");
	property p_stat_bits;
		$rose(status) |-> (stat_low_reg % BIT_I == 0) && (stat_low_reg <= 9 * BIT_I);
	endproperty
	a_stat_bits: assert property (p_stat_bits)
		else $error("status low run not whole bit times");
	property p_cmd_start;
		$fell(command) |=> (!command)[*7];
	endproperty
	a_cmd_start: assert property (p_cmd_start)
		else $error("command start bit too short");
	property p_stat_start;
		$fell(status) |-> (!status)[*8];
	endproperty
	a_stat_start: assert property (p_stat_start)
		else $error("status start bit too short");
	property p_cmd_high;
		$rose(command) |-> command[*8];
	endproperty
	a_cmd_high: assert property (p_cmd_high)
		else $error("command high bit too short");
	property p_stat_high;
		$rose(status) |-> status[*8];
	endproperty
	a_stat_high: assert property (p_stat_high)
		else $error("status high bit too short");
	property p_reset_idle;
		$rose(ARST_N_I) |-> command && status && engine_ready_n && key_change_n && hsync_n
			&& vsync_n && print_request_n && !video_p;
	endproperty
	a_reset_idle: assert property (p_reset_idle)
		else $error("lines not idle after reset");
	property p_video_page;
		video_p |-> !vsync_n;
	endproperty
	a_video_page: assert property (p_video_page)
		else $error("video dot outside a page");
	c_cmd_frame: cover property ($fell(command));
	c_stat_frame: cover property ($fell(status));
	c_video_dot: cover property ($rose(video_p));
	c_line_start: cover property ($fell(hsync_n) && !vsync_n);
endmodule

// File: verif/testbench.sv
// Self-checking bench: engine and controller joined over the link
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [15:0] BITC = 16'h0010;
	localparam int BC = 16;
	logic clk = 1'b0;
	logic arst_n = 1'b0;
	logic cmd_valid = 1'b0;
	logic [7:0] cmd_data = 8'h00;
	logic [7:0] e_stat_data = 8'h00;
	logic [7:0] key = 8'h00;
	logic [7:0] c_stat_data;
	logic [7:0] e_cmd_data;
	logic cmd_ready, c_stat_valid, c_stat_err, c_eng_ready, c_key, c_page, vid_ready;
	logic e_cmd_valid, e_link_up, e_stat_ready, e_print_req, e2_valid, e2_err;
	logic print_req = 1'b0, vid_valid = 1'b0, vid_data = 1'b0, e_stat_valid = 1'b0;
	logic ready = 1'b0, vsync = 1'b0, hsync = 1'b0, vid_on = 1'b0, exp_vp = 1'b0, cmd2 = 1'b1;
	int pix = 0, e2_oks = 0, e2_errs = 0, mismatches = 0, checks_done = 0;
	logic [31:0] seed = 32'h0CB0;
	logic [7:0] cmd_q[$];
	logic [7:0] wcmd_q[$];
	logic [7:0] wstat_q[$];
	// ************************************************************
	// Design, second engine for faulty frames, checker
	// ************************************************************
	pei_if if1();
	pei_if if2();
	assign if2.command = cmd2;
	assign if2.print_request_n = 1'b1;
	assign if2.video_p = 1'b0;
	assign if2.video_n = 1'b1;
	pei_controller #(.BIT_CYCLES(BITC), .LINE_PIXELS(16'h0008)) pei_controller_inst (
		.CLK_I(clk), .ARST_N_I(arst_n), .LINK(if1.controller), .CMD_VALID_I(cmd_valid),
		.CMD_DATA_I(cmd_data), .CMD_READY_O(cmd_ready), .STAT_VALID_O(c_stat_valid),
		.STAT_DATA_O(c_stat_data), .STAT_ERR_O(c_stat_err), .PRINT_REQ_I(print_req),
		.ENG_READY_O(c_eng_ready), .KEY_CHANGED_O(c_key), .PAGE_ACTIVE_O(c_page),
		.VID_VALID_I(vid_valid), .VID_DATA_I(vid_data), .VID_READY_O(vid_ready));
	pei_engine #(.BIT_CYCLES(BITC)) pei_engine_inst (
		.CLK_I(clk), .ARST_N_I(arst_n), .LINK(if1.engine), .CMD_VALID_O(e_cmd_valid),
		.CMD_DATA_O(e_cmd_data), .CMD_ERR_O(), .LINK_UP_O(e_link_up), .STAT_VALID_I(e_stat_valid),
		.STAT_DATA_I(e_stat_data), .STAT_READY_O(e_stat_ready), .READY_I(ready), .KEY_I(key),
		.VSYNC_I(vsync), .HSYNC_I(hsync), .PRINT_REQ_O(e_print_req), .VIDEO_BIT_O());
	pei_engine #(.BIT_CYCLES(BITC)) pei_engine_fault_inst (
		.CLK_I(clk), .ARST_N_I(arst_n), .LINK(if2.engine), .CMD_VALID_O(e2_valid),
		.CMD_DATA_O(), .CMD_ERR_O(e2_err), .LINK_UP_O(), .STAT_VALID_I(1'b1),
		.STAT_DATA_I(8'h00), .STAT_READY_O(), .READY_I(ready), .KEY_I(key),
		.VSYNC_I(vsync), .HSYNC_I(hsync), .PRINT_REQ_O(), .VIDEO_BIT_O());
	pei_link_props #(.BIT_CYCLES(BITC)) pei_link_props_inst (
		.CLK_I(clk), .ARST_N_I(arst_n), .command(if1.command), .status(if1.status),
		.engine_ready_n(if1.engine_ready_n), .print_request_n(if1.print_request_n),
		.key_change_n(if1.key_change_n), .vsync_n(if1.vsync_n), .hsync_n(if1.hsync_n),
		.video_p(if1.video_p), .video_n(if1.video_n));
	// ************************************************************
	// Helpers
	// ************************************************************
	always #2 clk = ~clk;
	function automatic logic [7:0] rnd8();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed[7:0];
	endfunction
	function automatic logic [10:0] mk_frame(input logic [7:0] d, input logic bp, input logic bs);
		return {~bs, (~^d) ^ bp, d, 1'b0};
	endfunction
	function automatic logic pick(input int k);
		return k == 0 ? e_cmd_valid : (k == 1 ? e_stat_ready : c_stat_valid);
	endfunction
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			mismatches++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic end_of_test();
		$display("Checks %0d, mismatches %0d", checks_done, mismatches);
		if (checks_done > 0 && mismatches == 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	task automatic wait_sel(input int k);
		int n;
		n = 0;
		while (pick(k) !== 1'b1 && n < 3000) begin
			@(posedge clk);
			#1;
			n++;
		end
		check("handshake seen", 32'(pick(k)), 32'h1);
	endtask
	// One command through the engine, answered with a random status byte
	task automatic serve(input logic [7:0] exp);
		logic [7:0] s;
		s = rnd8();
		wait_sel(0);
		check("engine command", 32'(e_cmd_data), 32'(exp));
		wait_sel(1);
		wstat_q.push_back(s);
		@(posedge clk);
		e_stat_valid <= 1'b1;
		e_stat_data <= s;
		@(posedge clk);
		e_stat_valid <= 1'b0;
		wait_sel(2);
		check("status byte", 32'(c_stat_data), 32'(s));
		check("status error", 32'(c_stat_err), 32'h0);
	endtask
	task automatic grab(input int sel, output logic [10:0] f);
		while ((sel == 0 ? if1.command : if1.status) !== 1'b0) @(negedge clk);
		repeat (BC / 2) @(posedge clk);
		for (int i = 0; i < 11; i++) begin
			#1;
			f[i] = sel == 0 ? if1.command : if1.status;
			if (i < 10) repeat (BC) @(posedge clk);
		end
	endtask
	task automatic send2(input logic [10:0] f);
		for (int i = 0; i < 11; i++) begin
			cmd2 <= f[i];
			repeat (BC) @(posedge clk);
		end
	endtask
	// ************************************************************
	// Monitors and video source
	// ************************************************************
	for (genvar g = 0; g < 2; g++) begin : g_mon
		initial begin
			logic [10:0] f;
			logic [7:0] d;
			@(posedge arst_n);
			forever begin
				grab(g, f);
				d = g == 0 ? wcmd_q.pop_front() : wstat_q.pop_front();
				check("wire frame", 32'(f), 32'(mk_frame(d, 1'b0, 1'b0)));
			end
		end
	end
	always @(posedge clk) begin
		if (vid_ready === 1'b1) pix <= pix + 1;
		exp_vp <= vid_ready === 1'b1 && vid_valid && vid_data;
		e2_oks <= e2_oks + int'(e2_valid === 1'b1);
		e2_errs <= e2_errs + int'(e2_err === 1'b1);
		if (vid_on) begin
			vid_valid <= rnd8() > 8'h30;
			vid_data <= ^rnd8();
		end
	end
	always @(negedge clk) if (vid_on) check("video dot", 32'(if1.video_p), 32'(exp_vp));
	initial begin
		repeat (40000) @(posedge clk);
		mismatches++;
		end_of_test();
	end
	// ************************************************************
	// Main sequence
	// ************************************************************
	initial begin
		int pushed, p0;
		logic [7:0] v;
		logic acc;
		wcmd_q.push_back(pei_pkg::INIT_CMD);
		repeat (8) @(posedge clk);
		arst_n <= 1'b1;
		@(posedge clk);
		// Fill the queue while the init reply is held back
		pushed = 0;
		for (int i = 0; i < 20; i++) begin
			v = rnd8();
			cmd_valid <= 1'b1;
			cmd_data <= v;
			@(negedge clk);
			acc = cmd_ready;
			@(posedge clk);
			if (acc !== 1'b1) break;
			cmd_q.push_back(v);
			wcmd_q.push_back(v);
			pushed++;
		end
		cmd_valid <= 1'b0;
		check("queue depth", 32'(pushed), 32'(pei_pkg::FIFO_DEPTH));
		serve(pei_pkg::INIT_CMD);
		check("link up", 32'(e_link_up), 32'h1);
		key <= rnd8() | 8'h01;
		repeat (8) @(posedge clk);
		check("key flag", 32'(c_key), 32'h1);
		check("key pin", 32'(if1.key_change_n), 32'h0);
		while (cmd_q.size() > 0) serve(cmd_q.pop_front());
		check("key cleared", 32'(c_key), 32'h0);
		for (int b = 1; b >= 0; b--) begin
			ready <= b[0];
			print_req <= b[0];
			repeat (8) @(posedge clk);
			check("engine ready", 32'(c_eng_ready), 32'(b[0]));
			check("ready pin", 32'(if1.engine_ready_n), 32'(!b[0]));
			check("print request", 32'(e_print_req), 32'(b[0]));
		end
		vsync <= 1'b1;
		vid_on <= 1'b1;
		repeat (8) @(posedge clk);
		check("page active", 32'(c_page), 32'h1);
		for (int l = 0; l < 2; l++) begin
			p0 = pix;
			hsync <= 1'b1;
			repeat (2) @(posedge clk);
			hsync <= 1'b0;
			repeat (30) @(posedge clk);
			check("line pixels", 32'(pix - p0), 32'd8);
		end
		vid_on <= 1'b0;
		vsync <= 1'b0;
		send2(mk_frame(pei_pkg::INIT_CMD, 1'b0, 1'b0));
		cmd2 <= 1'b1;
		repeat (BC * 14) @(posedge clk);
		send2(mk_frame(8'hA5, 1'b1, 1'b0));
		send2(mk_frame(8'h3C, 1'b0, 1'b1));
		cmd2 <= 1'b1;
		repeat (BC * 2) @(posedge clk);
		check("bad frames flagged", 32'(e2_errs), 32'd2);
		check("good frames", 32'(e2_oks), 32'd1);
		end_of_test();
	end
endmodule
